// [hdl/bbm_pkg.sv]
// Constants and types for the invalid-block tracking logic
package bbm_pkg;
  localparam int BLK_W = 13;
  localparam int PAGE_W = 6;
  localparam int CNT_W = 14;
  localparam logic [CNT_W-1:0] BLOCK_COUNT = 14'h2000;
  localparam logic [CNT_W-1:0] MIN_GOOD = 14'h1F60;
  localparam logic [BLK_W-1:0] LAST_BLOCK = 13'h1FFF;
  localparam logic [BLK_W-1:0] BOOT_BLOCK = 13'h0000;
  localparam logic [PAGE_W-1:0] MARK_PAGES = 6'h02;
  localparam logic [7:0] MARK_GOOD = 8'hFF;
  localparam logic [7:0] MARK_BAD = 8'h00;

  typedef enum logic [1:0] {
    OP_READ_MARK = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_ERASE = 2'b10,
    OP_FACTORY_MARK = 2'b11
  } op_e;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_LOOK = 2'b10,
    ST_ACT = 2'b11
  } state_e;
endpackage

// [hdl/bad_map_if.sv]
// Port bundle between the controller and the bad-block flag memory
`timescale 1ns/1ps
interface bad_map_if;
  import bbm_pkg::*;
  logic [BLK_W-1:0] addr;
  logic we;
  logic wdata;
  logic rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

// [hdl/bad_map_mem.sv]
// One flag bit per block, registered read
`timescale 1ns/1ps
module bad_map_mem
  import bbm_pkg::*;
(
  input wire logic clk,
  bad_map_if.mem port
);
  logic flags [0:(1<<BLK_W)-1];

  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      flags[port.addr] <= port.wdata;
    end
    port.rdata <= flags[port.addr];
  end
endmodule

// [hdl/bad_block_keeper.sv]
// Invalid-block keeper: factory marks, marker reads, program/erase status
// How it works
// (R1) Block zero can never be marked bad; it always reads good.
// (R2) Marking stops once good blocks would drop below the minimum.
// (R3) Bad block reads a non-all-ones marker on page 0 or 1 byte 0.
// (R4) After reset the map is swept clear: every marker reads all ones.
// (R5) Host scans markers first; erasing a flagged block wipes its marker.
// (R6) Host reads status after program and erase; fail is reported here.
// (R7) Host applies one-bit ECC per 528 bytes; not handled here.
// (R8) Host relocates data from failed blocks and retires them.
// (R9) Host programs pages in ascending order within a block.
// (R10) A bad block fails its program and erase operations and touches no other block.
// (R11) Host raises a flag with the block number on bad finds.
`timescale 1ns/1ps
module bad_block_keeper
  import bbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [BLK_W-1:0] op_block,
  input wire logic [PAGE_W-1:0] op_page,
  output logic ready,
  output logic done,
  output logic fail,
  output logic [7:0] marker,
  output logic [CNT_W-1:0] good_count
);
  bad_map_if map ();

  state_e state;
  state_e next_state;
  op_e op_q;
  logic [BLK_W-1:0] blk_q;
  logic [PAGE_W-1:0] page_q;
  logic [BLK_W-1:0] sweep;
  logic [CNT_W-1:0] next_good_count;
  logic [7:0] next_marker;
  logic next_fail;
  logic [BLK_W-1:0] next_sweep;
  logic next_ready;

  bad_map_mem flag_mem (
    .clk(clk),
    .port(map)
  );

  // Request decode
  wire take = (state == ST_IDLE) && op_valid;
  wire sweeping = (state == ST_INIT);
  wire sweep_last = (sweep == LAST_BLOCK);
  wire act = (state == ST_ACT);
  wire is_read = (op_q == OP_READ_MARK);
  wire is_program = (op_q == OP_PROGRAM);
  wire is_erase = (op_q == OP_ERASE);
  wire is_mark = (op_q == OP_FACTORY_MARK);
  wire is_boot = (blk_q == BOOT_BLOCK); // see (R1)
  wire above_floor = (good_count > MIN_GOOD); // see (R2)
  wire is_bad = map.rdata && !is_boot; // see (R1)
  wire in_marker_page = (page_q < MARK_PAGES); // see (R3)

  // Flag updates: marking, refusing, wiping
  wire mark_allowed = !is_boot && above_floor; // see (R2)
  wire mark_ok = act && is_mark && !is_bad && mark_allowed;
  wire mark_refused = is_mark && !is_bad && !mark_allowed;
  wire wipe = act && is_erase && is_bad; // see (R5)

  // Map port steering
  assign map.addr = sweeping ? sweep : blk_q;
  assign map.we = sweeping || mark_ok || wipe; // see (R4)
  assign map.wdata = sweeping ? 1'b0 : mark_ok;

  // Marker byte: only byte 0 of the first two pages carries it
  assign next_marker = (is_read && is_bad && in_marker_page)
    ? MARK_BAD : MARK_GOOD; // see (R3)

  // Status: program or erase on a bad block fails, as does a refused mark; others pass
  assign next_fail = ((is_program || is_erase) && is_bad)
    || mark_refused; // see (R10)

  // Good-block count follows every mark and wipe
  assign next_good_count = mark_ok ? good_count - 14'h0001
    : (wipe ? good_count + 14'h0001 : good_count);

  // Sweep address walks only while clearing
  assign next_sweep = sweeping ? sweep + 13'h0001 : sweep; // see (R4)
  assign next_ready = (next_state == ST_IDLE);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_INIT: next_state = sweep_last ? ST_IDLE : ST_INIT;
      ST_IDLE: next_state = take ? ST_LOOK : ST_IDLE;
      ST_LOOK: next_state = ST_ACT;
      ST_ACT: next_state = ST_IDLE;
    endcase
  end

  // Sequencer state and sweep
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_INIT;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sweep <= '0;
    end
    else
    begin
      sweep <= next_sweep;
    end
  end

  // Request capture
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_q <= OP_READ_MARK;
    end
    else if (take)
    begin
      op_q <= op_e'(op_code);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blk_q <= '0;
    end
    else if (take)
    begin
      blk_q <= op_block;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      page_q <= '0;
    end
    else if (take)
    begin
      page_q <= op_page;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready <= 1'b0;
    end
    else
    begin
      ready <= next_ready;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= act;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fail <= 1'b0;
    end
    else if (act)
    begin
      fail <= next_fail; // see (R6)
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      marker <= MARK_GOOD;
    end
    else if (act)
    begin
      marker <= next_marker; // see (R3)
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      good_count <= BLOCK_COUNT;
    end
    else
    begin
      good_count <= next_good_count; // see (R2)
    end
  end
endmodule

// [dv/bbm_props.sv]
// Checker for the invalid-block keeper
`timescale 1ns/1ps
module bbm_props
  import bbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [BLK_W-1:0] op_block,
  input wire logic [PAGE_W-1:0] op_page,
  input wire logic ready,
  input wire logic [CNT_W-1:0] good_count,
  input wire logic done,
  input wire logic fail,
  input wire logic [7:0] marker
);
  wire t = op_valid && ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_boot; t && op_code == 2'h3 && op_block == 13'h0
    |-> ##3 fail; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  property p_floor; t && op_code == 2'h3 && good_count == MIN_GOOD
    |-> ##3 good_count == MIN_GOOD; endproperty
  a_floor: assert property (p_floor) else $error("floor");
  property p_page; t && op_code == 2'h0 && op_page > 6'h1
    |-> ##3 marker == 8'hFF; endproperty
  a_page: assert property (p_page) else $error("page");
  property p_sweep; $rose(rst_b)
    |-> good_count == BLOCK_COUNT && !ready; endproperty
  a_sweep: assert property (p_sweep) else $error("sweep");
  property p_keep; t && op_code == 2'h1
    |-> ##3 $stable(good_count); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  c_fail: cover property (done && fail);
  c_bad: cover property (done && marker == 8'h00);
  c_erase: cover property (t && op_code == 2'h2);
endmodule
bind bad_block_keeper bbm_props u_props (.*);

// [dv/host_model.sv]
// Host side issuing one request at a time
`timescale 1ns/1ps
module host_model
  import bbm_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  output logic op_valid = 1'b0,
  output logic [1:0] op_code = '0,
  output logic [BLK_W-1:0] op_block = '0,
  output logic [PAGE_W-1:0] op_page = '0
);
  task req(int c, int b, int p);
    @(negedge clk);
    {op_valid, op_code, op_block, op_page} = {1'b1, c[1:0], b[12:0], p[5:0]};
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    {op_valid, op_code, op_block, op_page} = ~{1'b1, c[1:0], b[12:0], p[5:0]};
  endtask
endmodule

// [dv/tb.sv]
// Bench for the invalid-block keeper
`timescale 1ns/1ps
module tb;
  import bbm_pkg::*;
  logic clk = 0, rst_b = 0, op_valid, ready, done, fail;
  logic [1:0] op_code;
  logic [BLK_W-1:0] op_block;
  logic [PAGE_W-1:0] op_page;
  logic [7:0] marker;
  logic [CNT_W-1:0] good_count;
  logic [23:0] q[$], e;
  bit bad[8192];
  int err_count, n_checks, good = 8192, cyc, b, n, s, flag_count, exp_flags;
  initial forever #25 clk = ~clk;
  host_model u_host (.*);
  bad_block_keeper u_dut (.*);
  task op(int c, int k, int p);
    bit f;
    f = c inside {1, 2} && bad[k];
    if (c == 3) f = !k || !bad[k] && good == MIN_GOOD;
    if (c == 2 && f) good++;
    if (c == 3 && !f && !bad[k]) good--;
    if (c == 2) bad[k] = 0;
    if (c == 3 && !f) bad[k] = 1;
    q.push_back({c == 0, f, c == 0 && p < 2 && bad[k] ? 8'h00 : 8'hFF,
      good[13:0]});
    if (c == 0 ? p < 2 && bad[k] : f) exp_flags++;
    u_host.req(c, k, p);
  endtask
  task conclude;
    n_checks++;
    if (q.size() != 0 || flag_count != exp_flags)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, flag_count, exp_flags);
    end
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(negedge clk)
    if (done === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 24'hFFFFFF;
      n_checks++;
      if ({fail, e[23] ? marker : e[21:14], good_count}
        !== e[22:0])
      begin
        err_count++;
        $display("CHECK FAILED %0t got %h exp %h", $time,
          {fail, marker, good_count}, e[22:0]);
      end
      if (e[23] ? marker !== MARK_GOOD : fail === 1'b1)
      begin
        flag_count++;
      end
    end
  always @(posedge clk)
    if (++cyc > 20000)
    begin
      err_count++;
      conclude();
    end
  initial
  begin
    void'($urandom(79910));
    b = 300 + $urandom % 7000;
    n = $urandom % 64;
    s = 1 + $urandom % 60;
    repeat (5) @(negedge clk);
    rst_b = 1;
    op(0, 0, 0);
    op(3, 0, 0);
    op(3, b, 0);
    for (int p = 0; p < 3; p++) op(0, b, p);
    op(0, b, 2 + $urandom % 62);
    op(1, b, n);
    op(1, b + 2, n);
    op(1, b + 1, 0);
    for (int p = s; p < s + 3; p++) op(1, b + 1, p);
    op(2, b, 0);
    op(0, b, 1);
    for (int k = 1; k < 163; k++) op(3, k, 0);
    repeat (5) @(negedge clk);
    conclude();
  end
endmodule
